//--- include/tmr8_defs.svh
// Register offsets, field positions, reset values and counts of the timer.
// Assumes a Wishbone slave with 32-bit data, one register per aligned word.
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

`define TMR8_OFS_CTRL_A 6'h00
`define TMR8_OFS_CTRL_B 6'h04
`define TMR8_OFS_COUNT 6'h08
`define TMR8_OFS_CMP_A 6'h0c
`define TMR8_OFS_CMP_B 6'h10
`define TMR8_OFS_MASK 6'h14
`define TMR8_OFS_FLAGS 6'h18
`define TMR8_OFS_IRQ_ACK 6'h1c

`define TMR8_RST_BYTE 8'h00
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00

`define TMR8_CTRL_A_MASK 8'hf3
`define TMR8_CTRL_B_MASK 8'h0f
`define TMR8_MASK_MASK 8'h07
`define TMR8_FLAGS_MASK 8'h07

`define TMR8_BIT_FOC_A 7
`define TMR8_BIT_FOC_B 6
`define TMR8_BIT_WGM_HI 3
`define TMR8_BIT_CMP_A 0
`define TMR8_BIT_OVF 1
`define TMR8_BIT_CMP_B 2

`define TMR8_PRE_W 10
`define TMR8_DIV_8 10'h007
`define TMR8_DIV_64 10'h03f
`define TMR8_DIV_256 10'h0ff
`define TMR8_DIV_1024 10'h3ff

`endif

//--- include/tmr8_pkg.sv
// Types shared by the timer and its bench.
// Assumes the defines header is compiled alongside.
package tmr8_pkg;

	typedef enum logic [2:0] {
		TMR8_WGM_NORMAL = 3'h0,
		TMR8_WGM_PC_FF = 3'h1,
		TMR8_WGM_CTC = 3'h2,
		TMR8_WGM_FAST_FF = 3'h3,
		TMR8_WGM_RSV4 = 3'h4,
		TMR8_WGM_PC_OCA = 3'h5,
		TMR8_WGM_RSV6 = 3'h6,
		TMR8_WGM_FAST_OCA = 3'h7
	} tmr8_wgm_t;

	typedef struct packed {
		logic [1:0] chan_a_output_mode;
		logic [1:0] chan_b_output_mode;
		logic [1:0] rsv;
		logic [1:0] waveform_mode_low;
	} tmr8_ctrl_a_t;

	typedef struct packed {
		logic force_compare_a;
		logic force_compare_b;
		logic [1:0] rsv;
		logic waveform_mode_high;
		logic [2:0] count_clock_select;
	} tmr8_ctrl_b_t;

	typedef struct packed {
		logic wave_out_a;
		logic wave_out_b;
		logic drive_a;
		logic drive_b;
	} tmr8_pins_t;

	typedef enum logic [1:0] {
		TMR8_DIR_UP = 2'b01,
		TMR8_DIR_DOWN = 2'b10
	} tmr8_dir_t;

endpackage : tmr8_pkg

//--- hdl/tmr8_timer.sv
// Eight-bit timer/counter with two compare channels, Wishbone slave.
// Assumes global interrupt enable comes from the system; the prescaler is internal.
// Summary of operation
// - Nonzero output-mode code hands the pin to the waveform, gated by direction; PWM code 01 does not, except on A with mode high bit set.
// - Non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clear on match set at TOP; 11 inverse.
// - PWM A code 01 toggles on match only when mode high bit set.
// - Phase-correct A: 10 clears up-counting, sets down-counting; 11 inverse.
// - Channel B matches A for 10/11 in PWM; 01 reserved, no toggle.
// - PWM match ignored when compare equals TOP and upper code bit set.
// - Waveform mode from two bits of control A plus one of B.
// - Modes 0,1,3 TOP 0xFF; 2,5,7 TOP compare A; 4,6 reserved.
// - Compare update immediate in 0/2, at TOP in PWM; overflow per mode.
// - Force strobe in non-PWM modes applies code; always reads zero.
// - Forced compare sets no flag and never clears the counter.
// - Clock select 000 stops, 001 direct, 010-101 divide 8/64/256/1024.
// - Select 110 falling, 111 rising external pin edge, pin drive ignored.
// - Counter readable and writable; write blocks the next compare match.
// - Both compare registers checked every timer clock; drive flag and pin.
// - Reserved bits of control A, control B and mask read zero.
// - Flags clear on vector acknowledge or on software writing one.
// - Overflow enable mask bit 1, compare A bit 0, gated by global.
// - Fast PWM counts to TOP and clears on the next timer clock.
`timescale 1ns/1ps
`include "tmr8_defs.svh"

module tmr8_timer
	import tmr8_pkg::*;
(
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Port and core context
	input wire logic external_count_pin_i,
	input wire logic dir_a_i,
	input wire logic dir_b_i,
	input wire logic global_irq_enable_i,
	input wire logic [2:0] vector_ack_i,
	// Pins and interrupts
	output tmr8_pins_t pins_o,
	output logic irq_cmp_a_o,
	output logic irq_ovf_o,
	output logic irq_cmp_b_o
);

	tmr8_ctrl_a_t ctrl_a_r;
	tmr8_ctrl_b_t ctrl_b_r;
	logic [7:0] count_r;
	logic [7:0] cmp_a_r;
	logic [7:0] cmp_b_r;
	logic [7:0] cmp_a_buf_r;
	logic [7:0] cmp_b_buf_r;
	logic [2:0] mask_r;
	logic [2:0] flags_r;
	logic [`TMR8_PRE_W-1:0] pre_r;
	logic [2:0] ext_sync_r;
	logic block_r;
	tmr8_dir_t dir_r;
	logic wave_a_r;
	logic wave_b_r;
	logic ack_r;
	logic [31:0] dat_r;

	tmr8_wgm_t wgm;
	logic is_pwm;
	logic is_pc;
	logic [7:0] top;
	logic tick;
	logic wr;
	logic rd;
	logic wr_count;
	logic match_a;
	logic match_b;
	logic at_top;
	logic at_bottom;
	logic ovf_ev;
	logic [7:0] count_nxt;
	logic [7:0] rd_byte;
	logic [2:0] set_ev;
	logic force_a;
	logic force_b;

	// Bus decode; one wait state keeps read data registered
	assign wr = cyc_i && stb_i && we_i && !ack_r && sel_i[0];
	assign rd = cyc_i && stb_i && !we_i && !ack_r;
	assign wr_count = wr && adr_i == `TMR8_OFS_COUNT;
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// Mode decode
	assign wgm = tmr8_wgm_t'({ctrl_b_r.waveform_mode_high,
		ctrl_a_r.waveform_mode_low});
	assign is_pwm = wgm == TMR8_WGM_PC_FF || wgm == TMR8_WGM_FAST_FF ||
		wgm == TMR8_WGM_PC_OCA || wgm == TMR8_WGM_FAST_OCA;
	assign is_pc = wgm == TMR8_WGM_PC_FF || wgm == TMR8_WGM_PC_OCA;
	assign top = (wgm == TMR8_WGM_CTC || wgm == TMR8_WGM_PC_OCA ||
		wgm == TMR8_WGM_FAST_OCA) ? cmp_a_r : `TMR8_MAX;

	// Timer clock enable from clock select
	always_comb begin
		case (ctrl_b_r.count_clock_select)
			3'h0: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = pre_r[2:0] == 3'(`TMR8_DIV_8);
			3'h3: tick = pre_r[5:0] == 6'(`TMR8_DIV_64);
			3'h4: tick = pre_r[7:0] == 8'(`TMR8_DIV_256);
			3'h5: tick = (pre_r == `TMR8_DIV_1024);
			3'h6: tick = ext_sync_r[2] && !ext_sync_r[1];
			3'h7: tick = !ext_sync_r[2] && ext_sync_r[1];
			default: tick = 1'b0;
		endcase
	end

	// Free-running prescaler, shared taps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// Pin sampling: bit 0 feeds only bit 1; the detector uses bits 1 and 2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_sync_r <= 3'h0;
		end else begin
			ext_sync_r <= {ext_sync_r[1:0], external_count_pin_i};
		end
	end

	assign match_a = tick && !block_r && count_r == cmp_a_r;
	assign match_b = tick && !block_r && count_r == cmp_b_r;
	assign at_top = tick && count_r == top;
	assign at_bottom = tick && count_r == `TMR8_BOTTOM;
	assign force_a = wr && adr_i == `TMR8_OFS_CTRL_B &&
		dat_i[`TMR8_BIT_FOC_A] && !is_pwm;
	assign force_b = wr && adr_i == `TMR8_OFS_CTRL_B &&
		dat_i[`TMR8_BIT_FOC_B] && !is_pwm;

	// Overflow point per mode
	always_comb begin
		case (wgm)
			TMR8_WGM_PC_FF, TMR8_WGM_PC_OCA: ovf_ev = at_bottom;
			TMR8_WGM_FAST_OCA: ovf_ev = at_top;
			default: ovf_ev = tick && count_r == `TMR8_MAX;
		endcase
	end

	// Next count per mode
	always_comb begin
		count_nxt = count_r;
		if (is_pc) begin
			if (dir_r == TMR8_DIR_UP) begin
				count_nxt = (count_r == top) ? count_r - 8'h01 : count_r + 8'h01;
			end else begin
				count_nxt = (count_r == `TMR8_BOTTOM) ? count_r + 8'h01 :
					count_r - 8'h01;
			end
		end else if (wgm == TMR8_WGM_NORMAL) begin
			count_nxt = count_r + 8'h01;
		end else begin
			// Clear whenever the count equals TOP, even with the match blocked; a force never reaches here
			count_nxt = (count_r == top) ? `TMR8_BOTTOM : count_r + 8'h01;
		end
	end

	// Counter and direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= `TMR8_RST_BYTE;
			dir_r <= TMR8_DIR_UP;
			block_r <= 1'b0;
		end else if (wr_count) begin
			count_r <= dat_i[7:0];
			block_r <= 1'b1;
		end else if (tick) begin
			count_r <= count_nxt;
			block_r <= 1'b0;
			if (is_pc && count_r == top) begin
				dir_r <= TMR8_DIR_DOWN;
			end else if (is_pc && count_r == `TMR8_BOTTOM) begin
				dir_r <= TMR8_DIR_UP;
			end
		end
	end

	// Compare registers; PWM modes load from the buffer at TOP
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_a_buf_r <= `TMR8_RST_BYTE;
			cmp_b_buf_r <= `TMR8_RST_BYTE;
			cmp_a_r <= `TMR8_RST_BYTE;
			cmp_b_r <= `TMR8_RST_BYTE;
		end else begin
			if (wr && adr_i == `TMR8_OFS_CMP_A) begin
				cmp_a_buf_r <= dat_i[7:0];
			end
			if (wr && adr_i == `TMR8_OFS_CMP_B) begin
				cmp_b_buf_r <= dat_i[7:0];
			end
			if (!is_pwm) begin
				cmp_a_r <= (wr && adr_i == `TMR8_OFS_CMP_A) ? dat_i[7:0] :
					cmp_a_buf_r;
				cmp_b_r <= (wr && adr_i == `TMR8_OFS_CMP_B) ? dat_i[7:0] :
					cmp_b_buf_r;
			end else if (at_top) begin
				cmp_a_r <= cmp_a_buf_r;
				cmp_b_r <= cmp_b_buf_r;
			end
		end
	end

	// Waveform outputs
	function automatic logic wave_next(input logic cur, input logic [1:0] code,
		input logic match, input logic forced, input logic chan_a);
		logic up;
		logic hit;
		logic at_cmp_top;
		wave_next = cur;
		up = dir_r == TMR8_DIR_UP;
		if (!is_pwm) begin
			if (match || forced) begin
				case (code)
					2'b01: wave_next = !cur;
					2'b10: wave_next = 1'b0;
					2'b11: wave_next = 1'b1;
					default: wave_next = cur;
				endcase
			end
		end else if (code == 2'b01) begin
			if (chan_a && ctrl_b_r.waveform_mode_high && match) begin
				wave_next = !cur;
			end
		end else if (code[1]) begin
			// Match at TOP is dropped; TOP action stands instead
			at_cmp_top = chan_a ? cmp_a_r == top : cmp_b_r == top;
			hit = match && !at_cmp_top;
			if (!is_pc) begin
				if (hit) begin
					wave_next = code[0];
				end else if (at_top) begin
					wave_next = !code[0];
				end
			end else if (hit) begin
				wave_next = up ? code[0] : !code[0];
			end else if (at_top && at_cmp_top) begin
				// Dual slope acts at TOP only for the dropped match
				wave_next = code[0] ? 1'b0 : 1'b1;
			end
		end
	endfunction : wave_next

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			wave_a_r <= wave_next(wave_a_r, ctrl_a_r.chan_a_output_mode,
				match_a, force_a, 1'b1);
			wave_b_r <= wave_next(wave_b_r, ctrl_a_r.chan_b_output_mode,
				match_b, force_b, 1'b0);
		end
	end

	// Pin override, gated by port direction
	always_comb begin
		pins_o.wave_out_a = wave_a_r;
		pins_o.wave_out_b = wave_b_r;
		pins_o.drive_a = (ctrl_a_r.chan_a_output_mode != 2'b00) && dir_a_i &&
			!(is_pwm && ctrl_a_r.chan_a_output_mode == 2'b01 &&
			!ctrl_b_r.waveform_mode_high);
		pins_o.drive_b = (ctrl_a_r.chan_b_output_mode != 2'b00) && dir_b_i &&
			!(is_pwm && ctrl_a_r.chan_b_output_mode == 2'b01);
	end

	// Control and mask registers; force bits are never stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_a_r <= tmr8_ctrl_a_t'(`TMR8_RST_BYTE);
			ctrl_b_r <= tmr8_ctrl_b_t'(`TMR8_RST_BYTE);
			mask_r <= 3'h0;
		end else if (wr) begin
			if (adr_i == `TMR8_OFS_CTRL_A) begin
				ctrl_a_r <= tmr8_ctrl_a_t'(dat_i[7:0] & `TMR8_CTRL_A_MASK);
			end
			if (adr_i == `TMR8_OFS_CTRL_B) begin
				ctrl_b_r <= tmr8_ctrl_b_t'(dat_i[7:0] & `TMR8_CTRL_B_MASK);
			end
			if (adr_i == `TMR8_OFS_MASK) begin
				mask_r <= dat_i[2:0] & 3'(`TMR8_MASK_MASK);
			end
		end
	end

	// Flags: hardware set wins over any clear in the same cycle
	assign set_ev = {match_b, ovf_ev, match_a};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= 3'h0;
		end else begin
			flags_r <= set_ev | (flags_r & ~vector_ack_i &
				~((wr && adr_i == `TMR8_OFS_FLAGS) ? dat_i[2:0] : 3'h0));
		end
	end

	assign irq_cmp_a_o = global_irq_enable_i && mask_r[`TMR8_BIT_CMP_A] &&
		flags_r[`TMR8_BIT_CMP_A];
	assign irq_ovf_o = global_irq_enable_i && mask_r[`TMR8_BIT_OVF] &&
		flags_r[`TMR8_BIT_OVF];
	assign irq_cmp_b_o = global_irq_enable_i && mask_r[`TMR8_BIT_CMP_B] &&
		flags_r[`TMR8_BIT_CMP_B];

	// Read mux; unmapped addresses read zero and still acknowledge
	always_comb begin
		case (adr_i)
			`TMR8_OFS_CTRL_A: rd_byte = ctrl_a_r & `TMR8_CTRL_A_MASK;
			`TMR8_OFS_CTRL_B: rd_byte = ctrl_b_r & `TMR8_CTRL_B_MASK;
			`TMR8_OFS_COUNT: rd_byte = count_r;
			`TMR8_OFS_CMP_A: rd_byte = cmp_a_buf_r;
			`TMR8_OFS_CMP_B: rd_byte = cmp_b_buf_r;
			`TMR8_OFS_MASK: rd_byte = {5'h00, mask_r};
			`TMR8_OFS_FLAGS: rd_byte = {5'h00, flags_r};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= cyc_i && stb_i && !ack_r;
			dat_r <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

endmodule : tmr8_timer

//--- bench/tmr8_timer_asserts.sv
// Checker of the timer's bus, pin drive and interrupt ports.
// Assumes it is bound to every tmr8_timer instance.
`timescale 1ns/1ps
module tmr8_timer_asserts
	import tmr8_pkg::*;
(
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Context and pins
	input wire logic dir_a_i,
	input wire logic dir_b_i,
	input wire logic global_irq_enable_i,
	input wire tmr8_pins_t pins_o,
	input wire logic irq_cmp_a_o,
	input wire logic irq_ovf_o,
	input wire logic irq_cmp_b_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ack_once;
		ack_o ##1 !ack_o;
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> s_ack_once)
		else $error("no single ack after request");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	AST_RD_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	AST_DRIVE_A: assert property (pins_o.drive_a |-> dir_a_i)
		else $error("pin a driven while input");
	AST_DRIVE_B: assert property (pins_o.drive_b |-> dir_b_i)
		else $error("pin b driven while input");
	AST_IRQ_A: assert property (irq_cmp_a_o |-> global_irq_enable_i)
		else $error("compare a irq without global");
	AST_IRQ_OVF: assert property (irq_ovf_o |-> global_irq_enable_i)
		else $error("overflow irq without global");
	AST_IRQ_B: assert property (irq_cmp_b_o |-> global_irq_enable_i)
		else $error("compare b irq without global");
endmodule : tmr8_timer_asserts

bind tmr8_timer tmr8_timer_asserts i_tmr8_timer_asserts (.*);

//--- bench/tmr8_timer_tb_top.sv
// Self-checking bench for the timer, driving its ports directly.
// Assumes the package, defines header and checker are compiled first.
`timescale 1ns/1ps
`include "tmr8_defs.svh"
module tmr8_timer_tb_top
	import tmr8_pkg::*;
;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [5:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, v;
	logic ack_o, ext = 0, dir_a = 1, dir_b = 1, glob = 1;
	logic [2:0] vack = 0;
	tmr8_pins_t pins_o;
	logic irq_a, irq_ovf, irq_b;
	logic [7:0] d;
	int num_errors = 0, cmp_count = 0, cycles = 0;
	tmr8_timer i_tmr8_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.external_count_pin_i(ext), .dir_a_i(dir_a), .dir_b_i(dir_b),
		.global_irq_enable_i(glob), .vector_ack_i(vack), .pins_o(pins_o),
		.irq_cmp_a_o(irq_a), .irq_ovf_o(irq_ovf), .irq_cmp_b_o(irq_b));
	always #12.5 clk_i = ~clk_i;
	task end_sim;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	// Hang guard, well above the roughly 1300 cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim;
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until ack is sampled, then idles one cycle
	task wb(input logic w, input logic [5:0] a, input logic [7:0] x);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h00_0000, x};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		d = dat_o[7:0];
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		@(posedge clk_i);
	endtask : wb
	function automatic logic [7:0] expv(input logic [5:0] a,
		input logic [7:0] x);
		case (a)
			`TMR8_OFS_CTRL_A: expv = x & `TMR8_CTRL_A_MASK;
			`TMR8_OFS_CTRL_B: expv = x & `TMR8_CTRL_B_MASK;
			`TMR8_OFS_MASK: expv = x & `TMR8_MASK_MASK;
			default: expv = x;
		endcase
	endfunction : expv
	task wc(input logic [5:0] a, input logic [7:0] x);
		wb(1, a, x);
		wb(0, a, 8'h00);
		chk(d, expv(a, x));
	endtask : wc
	initial begin
		v = $urandom(62);
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		for (int a = 0; a < 32; a += 4) begin
			wb(0, a[5:0], 8'h00);
			chk(d, 8'h00);
		end
		wc(`TMR8_OFS_IRQ_ACK, 8'h00);
		wb(1, `TMR8_OFS_IRQ_ACK, 8'hff);
		wc(`TMR8_OFS_CTRL_B, 8'hf0);
		wc(`TMR8_OFS_CTRL_A, 8'hff);
		wc(`TMR8_OFS_CTRL_A, 8'h00);
		wc(`TMR8_OFS_MASK, 8'hff);
		repeat (6) begin
			v = $urandom;
			wc(`TMR8_OFS_COUNT, v[7:0]);
			wc(`TMR8_OFS_CMP_B, v[15:8]);
		end
		// Forced compares in normal mode: set, then toggle
		wb(1, `TMR8_OFS_CTRL_A, 8'hf0);
		wb(1, `TMR8_OFS_CTRL_B, 8'hc0);
		chk({7'h00, pins_o.wave_out_a & pins_o.wave_out_b}, 8'h01);
		chk({7'h00, pins_o.drive_a & pins_o.drive_b}, 8'h01);
		wb(1, `TMR8_OFS_CTRL_A, 8'h50);
		wb(1, `TMR8_OFS_CTRL_B, 8'hc0);
		chk({7'h00, pins_o.wave_out_a | pins_o.wave_out_b}, 8'h00);
		wc(`TMR8_OFS_FLAGS, 8'h00);
		// Running count near MAX, both matches then wrap
		wb(1, `TMR8_OFS_COUNT, 8'hfa);
		wb(1, `TMR8_OFS_CMP_A, 8'hfc);
		wb(1, `TMR8_OFS_CMP_B, 8'hfd);
		wb(1, `TMR8_OFS_CTRL_B, 8'h01);
		for (int i = 0; i < 40 && irq_ovf !== 1'b1; i++) @(posedge clk_i);
		chk({7'h00, irq_ovf}, 8'h01);
		chk({6'h00, irq_a, irq_b}, 8'h03);
		chk({6'h00, pins_o.wave_out_a, pins_o.wave_out_b}, 8'h03);
		glob <= 0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({5'h00, irq_a, irq_ovf, irq_b}, 8'h00);
		@(posedge clk_i);
		glob <= 1;
		vack <= 3'b010;
		@(posedge clk_i);
		vack <= 3'b000;
		wb(0, `TMR8_OFS_FLAGS, 8'h00);
		chk(d, 8'h05);
		wb(1, `TMR8_OFS_FLAGS, 8'h05);
		wc(`TMR8_OFS_FLAGS, 8'h00);
		// Clear-on-match keeps the count at or below compare A
		wb(1, `TMR8_OFS_CTRL_B, 8'h00);
		wb(1, `TMR8_OFS_CTRL_A, 8'h02);
		wb(1, `TMR8_OFS_CMP_A, 8'h03);
		wb(1, `TMR8_OFS_COUNT, 8'h00);
		wb(1, `TMR8_OFS_CTRL_B, 8'h01);
		repeat (6) begin
			wb(0, `TMR8_OFS_COUNT, 8'h00);
			chk({7'h00, d <= 8'h03}, 8'h01);
		end
		// External rising edges clock the counter
		wb(1, `TMR8_OFS_CTRL_B, 8'h00);
		wb(1, `TMR8_OFS_CTRL_A, 8'h00);
		wb(1, `TMR8_OFS_COUNT, 8'h00);
		wb(1, `TMR8_OFS_CTRL_B, 8'h07);
		repeat (3) begin
			ext <= 1;
			repeat (4) @(posedge clk_i);
			ext <= 0;
			repeat (4) @(posedge clk_i);
		end
		wc(`TMR8_OFS_CTRL_B, 8'h00);
		wb(0, `TMR8_OFS_COUNT, 8'h00);
		chk(d, 8'h03);
		// Falling external edges only
		wb(1, `TMR8_OFS_COUNT, 8'h00);
		wb(1, `TMR8_OFS_CTRL_B, 8'h06);
		repeat (2) begin
			ext <= 1;
			repeat (4) @(posedge clk_i);
			ext <= 0;
			repeat (4) @(posedge clk_i);
		end
		wb(0, `TMR8_OFS_COUNT, 8'h00);
		chk(d, 8'h02);
		// Divide by 8; prescaler phase is free, so allow 10 or 11 ticks
		wb(1, `TMR8_OFS_COUNT, 8'h00);
		wb(1, `TMR8_OFS_CTRL_B, 8'h02);
		repeat (80) @(posedge clk_i);
		wb(1, `TMR8_OFS_CTRL_B, 8'h00);
		wb(0, `TMR8_OFS_COUNT, 8'h00);
		chk({7'h00, d >= 8'h0a && d <= 8'h0b}, 8'h01);
		// Fast PWM: A clears at 0x40, B sets at 0xc0, TOP does the rest
		wb(1, `TMR8_OFS_CMP_A, 8'h40);
		wb(1, `TMR8_OFS_CMP_B, 8'hc0);
		wb(1, `TMR8_OFS_COUNT, 8'h3e);
		wb(1, `TMR8_OFS_CTRL_A, 8'hb3);
		wb(1, `TMR8_OFS_CTRL_B, 8'h01);
		repeat (8) @(posedge clk_i);
		chk({7'h00, pins_o.wave_out_a}, 8'h00);
		repeat (190) @(posedge clk_i);
		chk({6'h00, pins_o.wave_out_a, pins_o.wave_out_b}, 8'h02);
		repeat (100) @(posedge clk_i);
		chk({6'h00, pins_o.wave_out_a, pins_o.wave_out_b}, 8'h00);
		repeat (100) @(posedge clk_i);
		chk({6'h00, pins_o.wave_out_a, pins_o.wave_out_b}, 8'h01);
		wb(1, `TMR8_OFS_CTRL_A, 8'h73);
		chk({6'h00, pins_o.drive_a, pins_o.drive_b}, 8'h01);
		wb(1, `TMR8_OFS_CTRL_A, 8'hd3);
		chk({6'h00, pins_o.drive_a, pins_o.drive_b}, 8'h02);
		dir_a <= 0;
		@(posedge clk_i);
		chk({7'h00, pins_o.drive_a}, 8'h00);
		dir_a <= 1;
		// Phase correct: A low from up match through TOP to down match
		wb(1, `TMR8_OFS_CTRL_B, 8'h00);
		wb(1, `TMR8_OFS_CTRL_A, 8'h00);
		wb(1, `TMR8_OFS_CMP_A, 8'h40);
		wb(1, `TMR8_OFS_COUNT, 8'h00);
		wb(1, `TMR8_OFS_CTRL_A, 8'h81);
		wb(1, `TMR8_OFS_CTRL_B, 8'h01);
		repeat (100) @(posedge clk_i);
		chk({7'h00, pins_o.wave_out_a}, 8'h00);
		repeat (200) @(posedge clk_i);
		chk({7'h00, pins_o.wave_out_a}, 8'h00);
		repeat (200) @(posedge clk_i);
		chk({7'h00, pins_o.wave_out_a}, 8'h01);
		end_sim;
	end
endmodule : tmr8_timer_tb_top
